// File: reference_loss_and_auto_sequencer.sv
// Frequency reference loss supervisor and automatic step sequencer.
// Assumes an Avalon-MM master, synchronous terminal inputs and one core clock.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.

// What this block does
// - Choose digital or analog loss from source.
// - Keypad source: comm error for wait means loss.
// - Other sources: analog loss criterion decides.
// - Reaction none keeps previous frequency.
// - Reaction decel stops with configured deceleration.
// - Waiting time programmable, default one second.
// - Auto mode: off default, free-run, step-triggered.
// - Auto runs only from select and trigger terminals.
// - Selector register defaults to sequence one.
// - Step count per sequence defaults to two.
// - Free-run: one closure plays all steps.
// - Step-triggered: advance only on trigger closure.
// - New selection waits for running sequence end.
// - Each step stores frequency, times, direction.
// - Step pulse each step, sequence pulse last.
module reference_loss_and_auto_sequencer #(
  parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comm_err,
  input wire logic analog_loss,
  input wire logic [15:0] ref_freq,
  input wire logic sel_lo,
  input wire logic sel_mid,
  input wire logic sel_hi,
  input wire logic go_step,
  output logic [15:0] freq_cmd,
  output logic run_reverse,
  output logic coast_stop,
  output logic decel_stop,
  output logic auto_active,
  output logic step_pulse,
  output logic seq_pulse,
  output logic loss_flag,
  output logic irq
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYCLES + 1);

  seq_pkg::ctrl_t ctrl_r;
  logic [7:0] wait_r;
  logic [19:0] steps_r;
  logic [seq_pkg::IRQ_W-1:0] status_r, status_nxt, mask_r, events;
  logic [seq_pkg::TBL_AW-1:0] tbl_addr_r;
  logic ack_r, wr_ok, rd_ok, rd_take, tbl_wr;
  logic [31:0] rd_mux, readdata_r;
  seq_pkg::state_view_t view;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_ok = avs_write & ack_r;
  assign rd_ok = avs_read & ack_r;
  assign rd_take = avs_read & ~ack_r;
  assign tbl_wr = wr_ok && avs_address == seq_pkg::OFS_TBL_DATA;
  assign avs_readdata = readdata_r;

  always_comb begin
    case (avs_address)
      seq_pkg::OFS_CTRL: rd_mux = 32'(ctrl_r);
      seq_pkg::OFS_WAIT: rd_mux = 32'(wait_r);
      seq_pkg::OFS_STEPS: rd_mux = 32'(steps_r);
      seq_pkg::OFS_STATUS: rd_mux = 32'(status_r);
      seq_pkg::OFS_MASK: rd_mux = 32'(mask_r);
      seq_pkg::OFS_STATE: rd_mux = 32'(view);
      seq_pkg::OFS_TBL_ADDR: rd_mux = 32'(tbl_addr_r);
      default: rd_mux = 32'h0;
    endcase
  end

  // A status read clears only the bits it returned; a new event wins.
  assign status_nxt = events | (status_r & ~((rd_ok && avs_address == seq_pkg::OFS_STATUS) ?
                      readdata_r[seq_pkg::IRQ_W-1:0] : '0));
  assign irq = |(status_r & mask_r);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0;
      status_r <= '0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (rd_take) readdata_r <= rd_mux;
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= seq_pkg::CTRL_RST;
      wait_r <= seq_pkg::WAIT_RST;
      steps_r <= seq_pkg::STEPS_RST;
      mask_r <= '0;
      tbl_addr_r <= '0;
    end else if (wr_ok) begin
      case (avs_address)
        seq_pkg::OFS_CTRL: ctrl_r <= seq_pkg::ctrl_t'(avs_writedata[$bits(ctrl_r)-1:0]);
        seq_pkg::OFS_WAIT: wait_r <= avs_writedata[7:0];
        seq_pkg::OFS_STEPS: steps_r <= avs_writedata[seq_pkg::STEPS_W-1:0];
        seq_pkg::OFS_MASK: mask_r <= avs_writedata[seq_pkg::IRQ_W-1:0];
        seq_pkg::OFS_TBL_ADDR: tbl_addr_r <= avs_writedata[seq_pkg::TBL_AW-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Time base and reference loss
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt_r;
  logic tick, src_keypad, err_sel, loss_r, loss_nxt;
  logic [7:0] loss_cnt_r;
  logic [15:0] held_r;

  assign tick = tick_cnt_r == TW'(TICK_CYCLES - 1);
  assign src_keypad = ctrl_r.freq_src == seq_pkg::SRC_KEYPAD1 ||
                      ctrl_r.freq_src == seq_pkg::SRC_KEYPAD2;
  assign err_sel = src_keypad ? comm_err : analog_loss;
  assign loss_nxt = err_sel && loss_cnt_r >= wait_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      loss_cnt_r <= 8'h0;
      loss_r <= 1'b0;
      held_r <= 16'h0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
      if (!err_sel) loss_cnt_r <= 8'h0;
      else if (tick && loss_cnt_r != 8'hff) loss_cnt_r <= loss_cnt_r + 8'h1;
      loss_r <= loss_nxt;
      if (!loss_r) held_r <= ref_freq;
    end
  end

  // ----------------------------------------------------------------
  // Sequence selection from terminals
  // ----------------------------------------------------------------
  logic sel_any, sel_any_r, go_r, go_edge, closure, pend_r, start;
  logic [2:0] sel_code, pend_seq_r;

  assign sel_code = seq_pkg::seq_decode({sel_hi, sel_mid, sel_lo});
  assign sel_any = sel_hi | sel_mid | sel_lo;
  // Closure on the select terminals is the only way to start a run.
  assign closure = sel_any & ~sel_any_r & (ctrl_r.auto_mode != seq_pkg::AUTO_OFF);
  assign go_edge = go_step & ~go_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_any_r <= 1'b0;
      go_r <= 1'b0;
      pend_r <= 1'b0;
      pend_seq_r <= 3'h1;
    end else begin
      sel_any_r <= sel_any;
      go_r <= go_step;
      pend_r <= closure | (pend_r & ~start);
      if (closure) pend_seq_r <= (sel_code != 3'h0) ? sel_code : ctrl_r.seq_select;
    end
  end

  // ----------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------
  seq_pkg::seq_state_t state_r, state_nxt;
  seq_pkg::step_t entry_r, entry_nxt, rd_entry;
  logic [2:0] seq_r, seq_nxt, step_r, step_nxt, last_idx;
  logic [7:0] time_r, time_nxt;
  logic [31:0] acc_r, acc_nxt, total_r, total_nxt, acc_sum;
  logic [15:0] freq_r, freq_nxt, diff_r, diff_nxt;
  logic fetch_r, fetch_nxt, up_r, up_nxt, step_now, step_ev, seq_ev;
  logic [31:0] rd_word;

  step_table #(.AW(seq_pkg::TBL_AW), .DW(32)) u_table (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(tbl_wr),
    .wr_addr(tbl_addr_r),
    .wr_data(avs_writedata),
    .rd_addr({seq_r, step_r}),
    .rd_data_r(rd_word)
  );

  assign rd_entry = seq_pkg::step_t'(rd_word);
  assign last_idx = seq_pkg::step_last(steps_r, seq_r);
  assign acc_sum = acc_r + 32'(diff_r);
  // One unit per clock at most; a shortened tick may leave the ramp to snap at its end.
  assign step_now = acc_sum >= total_r;
  assign start = state_r == seq_pkg::S_IDLE && state_nxt == seq_pkg::S_FETCH;

  always_comb begin
    state_nxt = state_r;
    entry_nxt = entry_r;
    seq_nxt = seq_r;
    step_nxt = step_r;
    time_nxt = time_r;
    acc_nxt = acc_r;
    total_nxt = total_r;
    freq_nxt = freq_r;
    diff_nxt = diff_r;
    up_nxt = up_r;
    fetch_nxt = 1'b0;
    step_ev = 1'b0;
    seq_ev = 1'b0;
    case (state_r)
      seq_pkg::S_IDLE: begin
        if (pend_r) begin
          state_nxt = seq_pkg::S_FETCH;
          seq_nxt = pend_seq_r;
          step_nxt = 3'h0;
        end
      end
      seq_pkg::S_FETCH: begin
        fetch_nxt = ~fetch_r;
        if (fetch_r) begin
          entry_nxt = rd_entry;
          up_nxt = rd_entry.freq >= freq_r;
          diff_nxt = up_nxt ? rd_entry.freq - freq_r : freq_r - rd_entry.freq;
          total_nxt = 32'(rd_entry.trans) * 32'(TICK_CYCLES);
          time_nxt = 8'h0;
          acc_nxt = 32'h0;
          state_nxt = seq_pkg::S_RAMP;
        end
      end
      seq_pkg::S_RAMP: begin
        if (time_r >= entry_r.trans) begin
          freq_nxt = entry_r.freq;
          time_nxt = 8'h0;
          state_nxt = seq_pkg::S_HOLD;
        end else begin
          if (tick) time_nxt = time_r + 8'h1;
          acc_nxt = step_now ? acc_sum - total_r : acc_sum;
          if (step_now) freq_nxt = up_r ? freq_r + 16'h1 : freq_r - 16'h1;
        end
      end
      seq_pkg::S_HOLD: begin
        if (time_r >= {1'b0, entry_r.hold}) begin
          step_ev = 1'b1;
          time_nxt = 8'h0;
          if (step_r == last_idx) begin
            seq_ev = 1'b1;
            state_nxt = seq_pkg::S_IDLE;
          end else if (ctrl_r.auto_mode == seq_pkg::AUTO_B) begin
            state_nxt = seq_pkg::S_WAIT_GO;
          end else begin
            step_nxt = step_r + 3'h1;
            state_nxt = seq_pkg::S_FETCH;
          end
        end else if (tick) begin
          time_nxt = time_r + 8'h1;
        end
      end
      seq_pkg::S_WAIT_GO: begin
        if (go_edge) begin
          step_nxt = step_r + 3'h1;
          state_nxt = seq_pkg::S_FETCH;
        end
      end
      default: state_nxt = seq_pkg::S_IDLE;
    endcase
    if (ctrl_r.auto_mode == seq_pkg::AUTO_OFF) state_nxt = seq_pkg::S_IDLE;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= seq_pkg::S_IDLE;
      entry_r <= '0;
      seq_r <= 3'h1;
      step_r <= 3'h0;
      time_r <= 8'h0;
      acc_r <= 32'h0;
      total_r <= 32'h0;
      freq_r <= 16'h0;
      diff_r <= 16'h0;
      up_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      entry_r <= entry_nxt;
      seq_r <= seq_nxt;
      step_r <= step_nxt;
      time_r <= time_nxt;
      acc_r <= acc_nxt;
      total_r <= total_nxt;
      freq_r <= freq_nxt;
      diff_r <= diff_nxt;
      up_r <= up_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and events
  // ----------------------------------------------------------------
  logic busy;

  assign busy = state_r != seq_pkg::S_IDLE;
  assign events = {seq_ev, step_ev, loss_nxt & ~loss_r};
  assign view = '{freq: freq_r, pad: 3'h0, loss: loss_r, busy: busy, pending: pend_r,
                  dir: entry_r.dir, seq: seq_r, step: step_r, fsm: state_r};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      freq_cmd <= 16'h0;
      run_reverse <= 1'b0;
      coast_stop <= 1'b0;
      decel_stop <= 1'b0;
      auto_active <= 1'b0;
      step_pulse <= 1'b0;
      seq_pulse <= 1'b0;
      loss_flag <= 1'b0;
    end else begin
      freq_cmd <= busy ? freq_r : (loss_r ? held_r : ref_freq);
      run_reverse <= busy & entry_r.dir;
      coast_stop <= loss_r && ctrl_r.loss_react == seq_pkg::REACT_COAST;
      decel_stop <= loss_r && ctrl_r.loss_react == seq_pkg::REACT_DECEL;
      auto_active <= busy;
      step_pulse <= step_ev;
      seq_pulse <= seq_ev;
      loss_flag <= loss_r;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_keypad_loss: assert property ($rose(loss_r) && $past(src_keypad) |-> $past(comm_err))
    else $error("keypad loss without comm error");
  a_analog_loss: assert property ($rose(loss_r) && !$past(src_keypad) |-> $past(analog_loss))
    else $error("analog loss without criterion");
  a_loss_category: assert property ($rose(loss_r) |-> $past(err_sel))
    else $error("loss from unselected category");
  a_wait_full: assert property ($rose(loss_r) |-> $past(loss_cnt_r) >= $past(wait_r))
    else $error("loss before waiting time");
  a_hold_freq: assert property ((loss_r && !busy && ctrl_r.loss_react == seq_pkg::REACT_NONE)[*3]
    |-> $stable(freq_cmd))
    else $error("frequency moved during loss");
  a_decel_req: assert property (loss_r && ctrl_r.loss_react == seq_pkg::REACT_DECEL
    |=> decel_stop)
    else $error("no decel stop on loss");
  a_off_idle: assert property (ctrl_r.auto_mode == seq_pkg::AUTO_OFF |=> !busy)
    else $error("sequencer runs while off");
  a_go_wait: assert property (state_r == seq_pkg::S_WAIT_GO && !go_edge &&
    ctrl_r.auto_mode == seq_pkg::AUTO_B |=> state_r == seq_pkg::S_WAIT_GO)
    else $error("step advanced without trigger");
  a_seq_finish: assert property ($changed(seq_r) |-> $past(state_r) == seq_pkg::S_IDLE)
    else $error("sequence switched mid run");
  a_last_step: assert property (seq_ev |-> step_ev && step_r == last_idx)
    else $error("sequence ended off count");
  a_pulse_pair: assert property (seq_pulse |-> step_pulse)
    else $error("sequence pulse without step pulse");
  a_ramp_target: assert property (state_r == seq_pkg::S_HOLD |-> freq_r == entry_r.freq)
    else $error("hold not at step frequency");
  a_free_run: assert property (state_r == seq_pkg::S_HOLD && step_ev && !seq_ev &&
    ctrl_r.auto_mode == seq_pkg::AUTO_A |=> state_r == seq_pkg::S_FETCH)
    else $error("free run stalled");

  c_seq_done: cover property (seq_pulse);
  c_loss: cover property ($rose(loss_r));
  c_go: cover property (state_r == seq_pkg::S_WAIT_GO ##1 state_r == seq_pkg::S_FETCH);
  c_pending: cover property (busy && closure);

endmodule

// File: seq_pkg.sv
// Constants, register map and types shared by the reference supervisor files.
// Assumes a single 50 MHz core clock and a 32-bit register bus.
package seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * 1_000_000 / CLK_PERIOD_NS;
  // Waiting time is held in 100 ms ticks; 1.0 s default.
  localparam logic [7:0] WAIT_RST = 8'h0a;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_WAIT = 5'h04;
  localparam logic [4:0] OFS_STEPS = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_MASK = 5'h10;
  localparam logic [4:0] OFS_STATE = 5'h14;
  localparam logic [4:0] OFS_TBL_ADDR = 5'h18;
  localparam logic [4:0] OFS_TBL_DATA = 5'h1c;

  // ----------------------------------------------------------------
  // Codes and layouts
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_KEYPAD1 = 3'h0;
  localparam logic [2:0] SRC_KEYPAD2 = 3'h1;

  typedef enum logic [1:0] {
    REACT_NONE = 2'h0,
    REACT_COAST = 2'h1,
    REACT_DECEL = 2'h2
  } loss_react_t;

  typedef enum logic [1:0] {
    AUTO_OFF = 2'h0,
    AUTO_A = 2'h1,
    AUTO_B = 2'h2
  } auto_mode_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FETCH = 3'h1,
    S_RAMP = 3'h3,
    S_HOLD = 3'h2,
    S_WAIT_GO = 3'h6
  } seq_state_t;

  typedef struct packed {
    logic [2:0] seq_select;
    auto_mode_t auto_mode;
    loss_react_t loss_react;
    logic [2:0] freq_src;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{seq_select: 3'h1, auto_mode: AUTO_OFF,
                                 loss_react: REACT_NONE, freq_src: SRC_KEYPAD1};

  typedef struct packed {
    logic dir;
    logic [6:0] hold;
    logic [7:0] trans;
    logic [15:0] freq;
  } step_t;

  typedef struct packed {
    logic [15:0] freq;
    logic [2:0] pad;
    logic loss;
    logic busy;
    logic pending;
    logic dir;
    logic [2:0] seq;
    logic [2:0] step;
    seq_state_t fsm;
  } state_view_t;

  localparam int IRQ_W = 3;
  localparam int IRQ_LOSS = 0;
  localparam int IRQ_STEP = 1;
  localparam int IRQ_SEQ = 2;
  localparam int STEP_FIELD_W = 4;
  localparam int STEPS_W = 20;
  localparam logic [19:0] STEPS_RST = 20'h22222;
  localparam logic [3:0] MAX_STEPS = 4'h8;
  localparam int TBL_AW = 6;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic [2:0] seq_decode(input logic [2:0] hml);
    case (hml)
      3'h1: seq_decode = 3'h1;
      3'h2: seq_decode = 3'h2;
      3'h4: seq_decode = 3'h3;
      3'h3: seq_decode = 3'h4;
      3'h5: seq_decode = 3'h5;
      default: seq_decode = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] step_last(input logic [19:0] steps, input logic [2:0] seq);
    int idx;
    logic [3:0] n;
    idx = (int'(seq) - 1) * STEP_FIELD_W;
    if (idx < 0 || idx > STEPS_W - STEP_FIELD_W) idx = 0;
    n = steps[idx +: STEP_FIELD_W];
    if (n == 4'h0) step_last = 3'h0;
    else if (n > MAX_STEPS) step_last = 3'h7;
    else step_last = 3'(n - 4'h1);
  endfunction

endpackage

// File: step_table.sv
// Step table memory: one word per step of every sequence.
// Assumes writes from the bus side and a registered read for the sequencer.
module step_table #(
  parameter int AW = 6,
  parameter int DW = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_r
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule

// File: terminal_model.sv
// Far-side model: keypad link health, analog loss detector and input terminals.
// Assumes the bench calls its tasks from one process and that core_clk runs.
module terminal_model (
  output logic comm_err,
  output logic analog_loss,
  output logic [15:0] ref_freq,
  output logic sel_lo,
  output logic sel_mid,
  output logic sel_hi,
  output logic go_step,
  input wire logic core_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {comm_err, analog_loss, sel_lo, sel_mid, sel_hi, go_step} = 6'h00;
    ref_freq = 16'h0000;
  end

  // An open contact reads low, so a released terminal returns to 0.
  task automatic close_sel(input logic [2:0] hml);
    @(posedge core_clk);
    {sel_hi, sel_mid, sel_lo} <= hml;
    repeat (3) @(posedge core_clk);
    {sel_hi, sel_mid, sel_lo} <= 3'h0;
  endtask

  task automatic pulse_go();
    @(posedge core_clk);
    go_step <= 1'b1;
    repeat (3) @(posedge core_clk);
    go_step <= 1'b0;
  endtask

  task automatic set_err(input logic c, input logic a);
    @(posedge core_clk);
    comm_err <= c;
    analog_loss <= a;
  endtask

  task automatic set_ref(input logic [15:0] f);
    @(posedge core_clk);
    ref_freq <= f;
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the reference supervisor and step sequencer.
// Assumes the design files and terminal_model are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, comm_err, analog_loss, sel_lo, sel_mid, sel_hi, go_step;
  logic [15:0] ref_freq, freq_cmd, f, prev_freq;
  logic run_reverse, coast_stop, decel_stop, auto_active, step_pulse, seq_pulse;
  logic loss_flag, irq, prev_dir;
  logic [31:0] tbl [1:5][0:7];
  logic [17:0] exp_q [$];
  logic [17:0] mon_e;
  logic [2:0] codes [1:5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
  int cnt_eff [1:5] = '{2, 8, 1, 1, 8};
  logic [4:0] rst_a [8] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h18, 5'h1c, 5'h02};
  logic [31:0] rst_v [8] = '{32'h80, 32'h0a, 32'h22222, 0, 0, 0, 0, 0};
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int n;

  always #10 core_clk = ~core_clk;

  reference_loss_and_auto_sequencer #(.TICK_CYCLES(20)) reference_loss_and_auto_sequencer_inst (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comm_err(comm_err), .analog_loss(analog_loss),
    .ref_freq(ref_freq), .sel_lo(sel_lo), .sel_mid(sel_mid), .sel_hi(sel_hi),
    .go_step(go_step), .freq_cmd(freq_cmd), .run_reverse(run_reverse),
    .coast_stop(coast_stop), .decel_stop(decel_stop), .auto_active(auto_active),
    .step_pulse(step_pulse), .seq_pulse(seq_pulse), .loss_flag(loss_flag), .irq(irq));

  terminal_model terminal_model_inst (.comm_err(comm_err), .analog_loss(analog_loss),
    .ref_freq(ref_freq), .sel_lo(sel_lo), .sel_mid(sel_mid), .sel_hi(sel_hi),
    .go_step(go_step), .core_clk(core_clk));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      error_cnt++;
    end
  endtask

  // The request is held until waitrequest is sampled low; data is taken there.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_loss(input int lim);
    n = 0;
    while (loss_flag !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task automatic wait_idle();
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    chk("steps left", 0, 32'(exp_q.size()));
    repeat (4) @(posedge core_clk);
  endtask

  task automatic push_seq(input int s);
    for (int k = 0; k < cnt_eff[s]; k++) begin
      exp_q.push_back({k == cnt_eff[s] - 1, tbl[s][k][31], tbl[s][k][15:0]});
    end
  endtask

  // ----------------------------------------------------------------
  // Step monitor and hang guard
  // ----------------------------------------------------------------
  // The step word is judged one cycle before the pulse, while the step still owns the outputs.
  always @(posedge core_clk) begin
    if (step_pulse === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected step", 0, 1);
      else begin
        mon_e = exp_q.pop_front();
        chk("step freq", 32'(mon_e[15:0]), 32'(prev_freq));
        chk("step dir", 32'(mon_e[16]), 32'(prev_dir));
        chk("seq pulse", 32'(mon_e[17]), 32'(seq_pulse));
        chk("auto active", 1, 32'(auto_active));
      end
    end
    prev_freq = freq_cmd;
    prev_dir = run_reverse;
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n = $urandom(32'h5dc44374);
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rst_a[i]) begin
      bus(1'b0, rst_a[i], 32'h0);
      chk("reset value", rst_v[i], rd);
    end
    terminal_model_inst.close_sel(3'h1);
    repeat (20) @(posedge core_clk);
    chk("auto off", 0, 32'(auto_active));
    f = 16'($urandom);
    terminal_model_inst.set_ref(f);
    terminal_model_inst.set_err(1'b0, 1'b1);
    wait_loss(300);
    chk("analog ignored", 0, 32'(loss_flag));
    terminal_model_inst.set_err(1'b1, 1'b0);
    wait_loss(400);
    chk("loss delay", 1, 32'(n >= 180 && n <= 225));
    terminal_model_inst.set_ref(~f);
    repeat (5) @(posedge core_clk);
    chk("held freq", 32'(f), 32'(freq_cmd));
    chk("stops", 0, 32'({coast_stop, decel_stop}));
    chk("irq masked", 0, 32'(irq));
    bus(1'b1, 5'h10, 32'h1);
    @(posedge core_clk);
    chk("irq", 1, 32'(irq));
    bus(1'b0, 5'h0c, 32'h0);
    @(posedge core_clk);
    chk("status", 1, rd & 32'h1);
    chk("irq cleared", 0, 32'(irq));
    terminal_model_inst.set_err(1'b0, 1'b0);
    bus(1'b1, 5'h04, 32'h1);
    for (int r = 0; r < 3; r++) begin
      bus(1'b1, 5'h00, 32'h82 | 32'(r << 3));
      terminal_model_inst.set_err(1'b1, 1'b0);
      wait_loss(80);
      chk("comm ignored", 0, 32'(loss_flag));
      terminal_model_inst.set_err(1'b0, 1'b1);
      wait_loss(80);
      chk("reaction", 32'(r + 4), 32'({loss_flag, decel_stop, coast_stop}));
      terminal_model_inst.set_err(1'b0, 1'b0);
      repeat (5) @(posedge core_clk);
    end
    bus(1'b1, 5'h08, 32'h90182);
    for (int s = 1; s <= 5; s++) begin
      for (int k = 0; k < 8; k++) begin
        tbl[s][k] = {1'($urandom), 7'h01, 8'h01, 16'($urandom)};
        bus(1'b1, 5'h18, 32'({3'(s), 3'(k)}));
        bus(1'b1, 5'h1c, tbl[s][k]);
      end
    end
    bus(1'b1, 5'h00, 32'ha2);
    for (int s = 1; s <= 5; s++) begin
      push_seq(s);
      terminal_model_inst.close_sel(codes[s]);
      wait_idle();
    end
    push_seq(1);
    push_seq(3);
    terminal_model_inst.close_sel(3'h1);
    terminal_model_inst.close_sel(3'h4);
    wait_idle();
    bus(1'b1, 5'h00, 32'h1a2);
    push_seq(3);
    terminal_model_inst.close_sel(3'h6);
    wait_idle();
    bus(1'b1, 5'h00, 32'hc2);
    exp_q.push_back({1'b0, tbl[1][0][31], tbl[1][0][15:0]});
    terminal_model_inst.close_sel(3'h1);
    wait_idle();
    repeat (150) @(posedge core_clk);
    exp_q.push_back({1'b1, tbl[1][1][31], tbl[1][1][15:0]});
    terminal_model_inst.pulse_go();
    wait_idle();
    wrap_up();
  end
endmodule
